// >>> shared/scu_defs.svh
// Shared constants for the switch control serial link
`ifndef SCU_DEFS_SVH
`define SCU_DEFS_SVH
`define SCU_ADDR_FIXED 6'h24
`define SCU_DIR_WRITE 1'b0
`define SCU_DIR_READ 1'b1
`define SCU_BIT_ZERO 4'h0
`define SCU_BIT_ONE 4'h1
`define SCU_BYTE_BITS 4'h8
`define SCU_LAST_TX 4'h7
`define SCU_NUM_REGS 8
`define SCU_RD_FILL 8'h00
`define SCU_CNT_W 16
`define SCU_DLY_CYCLES 16'h03E8
`define SCU_CNT_ZERO 16'h0000
`define SCU_CNT_ONE 16'h0001
`define SCU_CLK_PERIOD_NS 8
`define SCU_SCL_PERIOD_NS 10000
`define SCU_QW 10
`define SCU_Q_DRIVE 2'h0
`define SCU_Q_RISE 2'h1
`define SCU_Q_MID 2'h2
`define SCU_Q_FALL 2'h3
`define SCU_STEP_START 3'h0
`define SCU_STEP_ADDR 3'h1
`define SCU_STEP_INDEX 3'h2
`define SCU_STEP_DATA 3'h3
`define SCU_STEP_RSTART 3'h3
`define SCU_STEP_RADDR 3'h4
`define SCU_STEP_WSTOP 3'h4
`define SCU_STEP_RBYTE 3'h5
`define SCU_STEP_RSTOP 3'h6
`endif

// >>> shared/scu_pkg.sv
// State types for both ends of the switch control link
`default_nettype none
package scu_pkg;
    typedef enum logic [3:0] {
        SLV_IDLE,
        SLV_ADDR,
        SLV_ACK_ADDR,
        SLV_INDEX,
        SLV_ACK_INDEX,
        SLV_WDATA,
        SLV_ACK_WDATA,
        SLV_RDATA,
        SLV_ACK_RDATA,
        SLV_WAIT
    } scu_slv_state_e;
    typedef enum logic [1:0] {
        MST_IDLE,
        MST_RUN,
        MST_DONE
    } scu_mst_state_e;
endpackage
`default_nettype wire

// >>> shared/scu_if.sv
// Two-wire serial bus joining the controller and the switch
`timescale 1ns/1ps
`default_nettype none
interface scu_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    wire scl;
    wire sda;
    // Open drain with pull-up: released lines read high
    assign scl = m_scl_oe ? m_scl_o : 1'b1;
    assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);
    modport master (
        input scl,
        input sda,
        output m_scl_o,
        output m_scl_oe,
        output m_sda_o,
        output m_sda_oe
    );
    modport slave (
        input scl,
        input sda,
        output s_sda_o,
        output s_sda_oe
    );
endinterface
`default_nettype wire

// >>> hdl/scu_slave.sv
// Switch end: serial slave, control arbitration and update windows
`timescale 1ns/1ps
`default_nettype none
`include "scu_defs.svh"
// Function
// - Low reset pin restores all defaults
// - Defaults equal the parallel pin state
// - Follow parallel pins until first serial event
// - Serial event locks out pins until reset
// - Address is 100100 plus select pin
// - Write direction zero; acknowledge matching address
// - Acknowledge index byte and hold as pointer
// - Store data byte at pointer; acknowledge it
// - After write: stop or repeated start
// - Read: index, repeated start, direction one
// - Send pointed register, MSB first
// - Master acknowledges read byte, then stops
// - Master ends with stop, releases bus
// - Serial delay starts at last bit fall
// - Parallel delay starts at pin change
// - Each register has own delay window
// - Writes accepted; physical state held meanwhile
// - Writes in window do not restart it
// - Window end applies latest value
// - Write after window applies, opens window
module scu_slave #(
    parameter int NUM_REGS = `SCU_NUM_REGS,
    parameter logic [NUM_REGS*`SCU_CNT_W-1:0] DLY_CYCLES =
        {NUM_REGS{`SCU_DLY_CYCLES}}
) (
    input wire logic clk,
    input wire logic rst,
    scu_if.slave bus,
    input wire logic reset_pin_n,
    input wire logic address_select_pin,
    input wire logic [NUM_REGS*8-1:0] par_cfg,
    output logic [NUM_REGS*8-1:0] phys_cfg,
    output logic [NUM_REGS-1:0] window_open,
    output logic serial_mode
);
    logic [1:0] rstn_s;
    logic [1:0] asel_s;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d;
    logic sda_d;
    logic [NUM_REGS*8-1:0] par_s1;
    logic [NUM_REGS*8-1:0] par_s2;
    logic [NUM_REGS*8-1:0] par_prev;
    logic [NUM_REGS*8-1:0] cfg_flat;
    scu_pkg::scu_slv_state_e state_reg, state_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] ptr_reg, ptr_next;
    logic rw_reg, rw_next;
    logic oe_reg, oe_next;
    logic lock_reg, lock_next;
    logic wr_stb;

    function automatic logic in_range(input logic [7:0] idx);
        in_range = (idx < NUM_REGS);
    endfunction

    // Every pin passes two flops before use
    always_ff @(posedge clk) begin
        if (rst) begin
            rstn_s <= 2'h0;
        end else begin
            rstn_s <= {rstn_s[0], reset_pin_n};
        end
    end

    always_ff @(posedge clk) begin
        asel_s <= {asel_s[0], address_select_pin};
        scl_s <= {scl_s[0], bus.scl};
        sda_s <= {sda_s[0], bus.sda};
        scl_d <= scl_s[1];
        sda_d <= sda_s[1];
        par_s1 <= par_cfg;
        par_s2 <= par_s1;
        par_prev <= par_s2;
    end

    wire srst = rst | ~rstn_s[1];
    wire scl_rise = scl_s[1] & ~scl_d;
    wire scl_fall = ~scl_s[1] & scl_d;
    wire start_det = scl_s[1] & scl_d & sda_d & ~sda_s[1];
    wire stop_det = scl_s[1] & scl_d & ~sda_d & sda_s[1];
    wire rx_state = (state_reg == scu_pkg::SLV_ADDR) |
                    (state_reg == scu_pkg::SLV_INDEX) |
                    (state_reg == scu_pkg::SLV_WDATA);
    wire byte_done = (bit_reg == `SCU_BYTE_BITS);
    wire addr_match = (shift_reg[7:1] ==
                       {`SCU_ADDR_FIXED, asel_s[1]});
    wire [7:0] rd_byte = in_range(ptr_reg) ?
                         cfg_flat[ptr_reg[2:0]*8 +: 8] : `SCU_RD_FILL;

    always_comb begin
        state_next = state_reg;
        bit_next = bit_reg;
        shift_next = shift_reg;
        ptr_next = ptr_reg;
        rw_next = rw_reg;
        oe_next = oe_reg;
        lock_next = lock_reg;
        wr_stb = 1'b0;
        if (stop_det) begin
            state_next = scu_pkg::SLV_IDLE;
            oe_next = 1'b0;
        end else if (start_det) begin
            // Repeated start re-enters addressing, pointer kept
            state_next = scu_pkg::SLV_ADDR;
            bit_next = `SCU_BIT_ZERO;
            oe_next = 1'b0;
        end else if (scl_rise && rx_state && !byte_done) begin
            shift_next = {shift_reg[6:0], sda_s[1]};
            bit_next = bit_reg + `SCU_BIT_ONE;
        end else if (scl_fall) begin
            unique case (state_reg)
                scu_pkg::SLV_ADDR: begin
                    if (byte_done && addr_match) begin
                        oe_next = 1'b1;
                        rw_next = shift_reg[0];
                        lock_next = 1'b1;
                        state_next = scu_pkg::SLV_ACK_ADDR;
                    end else if (byte_done) begin
                        state_next = scu_pkg::SLV_WAIT;
                    end
                end
                scu_pkg::SLV_ACK_ADDR: begin
                    bit_next = `SCU_BIT_ZERO;
                    if (rw_reg == `SCU_DIR_READ) begin
                        shift_next = rd_byte;
                        oe_next = ~rd_byte[7];
                        state_next = scu_pkg::SLV_RDATA;
                    end else begin
                        oe_next = 1'b0;
                        state_next = scu_pkg::SLV_INDEX;
                    end
                end
                scu_pkg::SLV_INDEX: begin
                    if (byte_done) begin
                        ptr_next = shift_reg;
                        oe_next = 1'b1;
                        state_next = scu_pkg::SLV_ACK_INDEX;
                    end
                end
                scu_pkg::SLV_ACK_INDEX: begin
                    oe_next = 1'b0;
                    bit_next = `SCU_BIT_ZERO;
                    state_next = scu_pkg::SLV_WDATA;
                end
                scu_pkg::SLV_WDATA: begin
                    if (byte_done) begin
                        // Fall of the last data bit starts the delay
                        wr_stb = 1'b1;
                        oe_next = 1'b1;
                        state_next = scu_pkg::SLV_ACK_WDATA;
                    end
                end
                scu_pkg::SLV_RDATA: begin
                    bit_next = bit_reg + `SCU_BIT_ONE;
                    if (bit_reg == `SCU_LAST_TX) begin
                        oe_next = 1'b0;
                        state_next = scu_pkg::SLV_ACK_RDATA;
                    end else begin
                        shift_next = {shift_reg[6:0], 1'b0};
                        oe_next = ~shift_reg[6];
                    end
                end
                // Only one byte per phase; extra bytes are ignored
                scu_pkg::SLV_ACK_WDATA: begin
                    oe_next = 1'b0;
                    state_next = scu_pkg::SLV_WAIT;
                end
                scu_pkg::SLV_ACK_RDATA: state_next = scu_pkg::SLV_WAIT;
                scu_pkg::SLV_IDLE, scu_pkg::SLV_WAIT: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= scu_pkg::SLV_IDLE;
            bit_reg <= `SCU_BIT_ZERO;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rw_reg <= `SCU_DIR_WRITE;
            oe_reg <= 1'b0;
            lock_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            ptr_reg <= ptr_next;
            rw_reg <= rw_next;
            oe_reg <= oe_next;
            lock_reg <= lock_next;
        end
    end

    assign bus.s_sda_o = 1'b0;
    assign bus.s_sda_oe = oe_reg;
    assign serial_mode = lock_reg;

    genvar i;
    generate
        for (i = 0; i < NUM_REGS; i++) begin : g_reg
            logic [7:0] cfg_reg;
            logic [7:0] phys_reg;
            logic [`SCU_CNT_W-1:0] cnt_reg;
            wire [7:0] par_byte = par_s2[i*8 +: 8];
            // Pins count only while unlocked
            wire par_evt = ~lock_reg &
                           (par_byte != par_prev[i*8 +: 8]);
            wire ser_evt = wr_stb & in_range(ptr_reg) &
                           (ptr_reg[2:0] == 3'(i));
            wire evt = par_evt | ser_evt;
            wire [7:0] evt_val = ser_evt ? shift_reg : par_byte;
            wire idle = (cnt_reg == `SCU_CNT_ZERO);
            wire ending = (cnt_reg == `SCU_CNT_ONE);
            always_ff @(posedge clk) begin
                if (srst) begin
                    cfg_reg <= par_byte;
                    phys_reg <= par_byte;
                    cnt_reg <= `SCU_CNT_ZERO;
                end else begin
                    if (evt) begin
                        cfg_reg <= evt_val;
                    end
                    if (idle && evt) begin
                        phys_reg <= evt_val;
                        cnt_reg <= DLY_CYCLES[i*`SCU_CNT_W +: `SCU_CNT_W];
                    end else if (!idle) begin
                        // Open window only counts down, never reloads
                        cnt_reg <= cnt_reg - `SCU_CNT_ONE;
                        if (ending) begin
                            phys_reg <= evt ? evt_val : cfg_reg;
                        end
                    end
                end
            end
            assign cfg_flat[i*8 +: 8] = cfg_reg;
            assign phys_cfg[i*8 +: 8] = phys_reg;
            assign window_open[i] = ~idle;
        end
    endgenerate
endmodule // scu_slave
`default_nettype wire

// >>> hdl/scu_master.sv
// Controller end: issues one register write or read per command
`timescale 1ns/1ps
`default_nettype none
`include "scu_defs.svh"
module scu_master #(
    parameter int QUARTER_CYCLES =
        `SCU_SCL_PERIOD_NS / `SCU_CLK_PERIOD_NS / 4
) (
    input wire logic clk,
    input wire logic rst,
    scu_if.master bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic cmd_addr_sel,
    input wire logic [7:0] cmd_index,
    input wire logic [7:0] cmd_wdata,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_nack
);
    scu_pkg::scu_mst_state_e state_reg, state_next;
    logic [`SCU_QW-1:0] qcnt_reg;
    logic [1:0] q_reg, q_next;
    logic [3:0] bit_reg, bit_next;
    logic [2:0] step_reg, step_next;
    logic [7:0] rx_reg, rx_next;
    logic nack_reg, nack_next;
    logic scl_low_reg, scl_low_next;
    logic sda_low_reg, sda_low_next;
    logic read_reg;
    logic asel_reg;
    logic [7:0] idx_reg;
    logic [7:0] wdata_reg;
    logic [1:0] sda_s;

    always_ff @(posedge clk) begin
        sda_s <= {sda_s[0], bus.sda};
    end

    // Divider makes the bus clock from four quarter phases
    wire tick = (qcnt_reg == `SCU_QW'(QUARTER_CYCLES - 1));
    wire take = cmd_valid & (state_reg == scu_pkg::MST_IDLE);
    wire is_start = (step_reg == `SCU_STEP_START) |
                    (read_reg & (step_reg == `SCU_STEP_RSTART));
    wire is_stop = read_reg ? (step_reg == `SCU_STEP_RSTOP) :
                              (step_reg == `SCU_STEP_WSTOP);
    wire rx_step = read_reg & (step_reg == `SCU_STEP_RBYTE);
    wire ack_bit = (bit_reg == `SCU_BYTE_BITS);
    wire [7:0] tx_byte =
        (step_reg == `SCU_STEP_ADDR) ?
            {`SCU_ADDR_FIXED, asel_reg, `SCU_DIR_WRITE} :
        (step_reg == `SCU_STEP_INDEX) ? idx_reg :
        read_reg ? {`SCU_ADDR_FIXED, asel_reg, `SCU_DIR_READ} :
        wdata_reg;
    wire tx_bit = tx_byte[3'h7 - bit_reg[2:0]];
    // Master acknowledges the single read byte
    wire drive_low = rx_step ? ack_bit : (~ack_bit & ~tx_bit);

    always_comb begin
        state_next = state_reg;
        q_next = q_reg;
        bit_next = bit_reg;
        step_next = step_reg;
        rx_next = rx_reg;
        nack_next = nack_reg;
        scl_low_next = scl_low_reg;
        sda_low_next = sda_low_reg;
        unique case (state_reg)
            scu_pkg::MST_IDLE: begin
                if (take) begin
                    state_next = scu_pkg::MST_RUN;
                    q_next = `SCU_Q_DRIVE;
                    step_next = `SCU_STEP_START;
                    bit_next = `SCU_BIT_ZERO;
                    nack_next = 1'b0;
                end
            end
            scu_pkg::MST_RUN: begin
                if (tick) begin
                    q_next = q_reg + 2'h1;
                    unique case (q_reg)
                        `SCU_Q_DRIVE: begin
                            scl_low_next = 1'b1;
                            sda_low_next = is_stop |
                                           (~is_start & drive_low);
                        end
                        `SCU_Q_RISE: scl_low_next = 1'b0;
                        `SCU_Q_MID: begin
                            if (is_start) begin
                                sda_low_next = 1'b1;
                            end else if (is_stop) begin
                                sda_low_next = 1'b0;
                            end else if (rx_step && !ack_bit) begin
                                rx_next = {rx_reg[6:0], sda_s[1]};
                            end else if (ack_bit && !rx_step) begin
                                nack_next = nack_reg | sda_s[1];
                            end
                        end
                        `SCU_Q_FALL: begin
                            if (is_stop) begin
                                state_next = scu_pkg::MST_DONE;
                            end else begin
                                scl_low_next = 1'b1;
                                if (is_start || ack_bit) begin
                                    step_next = step_reg + 3'h1;
                                    bit_next = `SCU_BIT_ZERO;
                                end else begin
                                    bit_next = bit_reg + `SCU_BIT_ONE;
                                end
                            end
                        end
                    endcase
                end
            end
            scu_pkg::MST_DONE: state_next = scu_pkg::MST_IDLE;
            default: state_next = scu_pkg::MST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst || take || tick) begin
            qcnt_reg <= '0;
        end else begin
            qcnt_reg <= qcnt_reg + `SCU_QW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= scu_pkg::MST_IDLE;
            q_reg <= `SCU_Q_DRIVE;
            bit_reg <= `SCU_BIT_ZERO;
            step_reg <= `SCU_STEP_START;
            rx_reg <= 8'h00;
            nack_reg <= 1'b0;
            scl_low_reg <= 1'b0;
            sda_low_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            q_reg <= q_next;
            bit_reg <= bit_next;
            step_reg <= step_next;
            rx_reg <= rx_next;
            nack_reg <= nack_next;
            scl_low_reg <= scl_low_next;
            sda_low_reg <= sda_low_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            read_reg <= 1'b0;
            asel_reg <= 1'b0;
            idx_reg <= 8'h00;
            wdata_reg <= 8'h00;
        end else if (take) begin
            read_reg <= cmd_read;
            asel_reg <= cmd_addr_sel;
            idx_reg <= cmd_index;
            wdata_reg <= cmd_wdata;
        end
    end

    assign cmd_ready = (state_reg == scu_pkg::MST_IDLE);
    assign rsp_valid = (state_reg == scu_pkg::MST_DONE);
    assign rsp_data = rx_reg;
    assign rsp_nack = nack_reg;
    assign bus.m_scl_o = 1'b0;
    assign bus.m_scl_oe = scl_low_reg;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_sda_oe = sda_low_reg;
endmodule // scu_master
`default_nettype wire

// >>> sim/scu_props.sv
// Wire-level checker for the switch control serial link
`timescale 1ns/1ps
`default_nettype none
`include "scu_defs.svh"
module scu_props #(
    parameter int DLY = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic m_sda_oe,
    input wire logic s_sda_oe,
    input wire logic scl,
    input wire logic sda,
    input wire logic reset_pin_n,
    input wire logic address_select_pin,
    input wire logic serial_mode,
    input wire logic [7:0] window_open
);
    logic scl_q, sda_q, busy, wr_ok, own_seen;
    logic [3:0] bitcnt;
    logic [1:0] bytecnt;
    logic [7:0] sh;
    logic [15:0] open_cnt;
    wire start_seen = scl && scl_q && sda_q && !sda;
    wire stop_seen = scl && scl_q && !sda_q && sda;
    wire scl_rise = scl && !scl_q;
    wire at_ack = busy && bitcnt == `SCU_BYTE_BITS;
    wire ack_rise = scl_rise && at_ack;
    wire addr_match = sh[7:1] == {`SCU_ADDR_FIXED, address_select_pin};
    wire addr_hit = at_ack && bytecnt == 2'h0 && addr_match;
    always_ff @(posedge clk) begin
        scl_q <= scl;
        sda_q <= sda;
        open_cnt <= window_open[0] ? open_cnt + 16'h0001 : 16'h0000;
    end
    // Bit and byte position since the last start or repeated start
    always_ff @(posedge clk) begin
        if (rst || start_seen) begin
            bitcnt <= 4'h0;
            bytecnt <= 2'h0;
        end else if (scl_rise && busy) begin
            bitcnt <= at_ack ? 4'h0 : bitcnt + 4'h1;
            if (at_ack && bytecnt != 2'h3) begin
                bytecnt <= bytecnt + 2'h1;
            end
            if (!at_ack) begin
                sh <= {sh[6:0], sda};
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst || stop_seen) begin
            busy <= 1'b0;
        end else if (start_seen) begin
            busy <= 1'b1;
        end
    end
    // Mode rises a few clocks after the last address bit falls, so keep it till start
    always_ff @(posedge clk) begin
        if (rst || start_seen) begin
            own_seen <= 1'b0;
            wr_ok <= 1'b0;
        end else begin
            own_seen <= own_seen || addr_hit;
            if (ack_rise && bytecnt == 2'h0) begin
                wr_ok <= addr_match && !sh[0];
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_slave_moves_low: assert property (
        $changed(s_sda_oe) |-> !scl)
        else $error("slave data moved while clock high");
    a_ack_held: assert property (
        $rose(s_sda_oe) |=> s_sda_oe [*4])
        else $error("slave released data too early");
    a_slave_in_frame: assert property (s_sda_oe |-> busy)
        else $error("slave drove data outside a frame");
    a_own_addr_ack: assert property (
        ack_rise && bytecnt == 2'h0 && addr_match |-> !sda)
        else $error("own address not acknowledged");
    a_foreign_nack: assert property (
        ack_rise && bytecnt == 2'h0 && !addr_match |-> sda)
        else $error("foreign address acknowledged");
    a_write_bytes_ack: assert property (
        ack_rise && wr_ok && bytecnt != 2'h3 |-> !sda && !m_sda_oe)
        else $error("write byte not acknowledged");
    a_mode_on_own: assert property (
        $rose(serial_mode) |-> own_seen)
        else $error("serial mode without own address");
    a_mode_sticky: assert property (
        $fell(serial_mode) |-> !reset_pin_n)
        else $error("serial mode dropped without reset");
    a_window_length: assert property (
        $fell(window_open[0]) |-> open_cnt == 16'(DLY))
        else $error("update window length wrong");
    c_write_ack: cover property (ack_rise && wr_ok);
    c_mode_entry: cover property ($rose(serial_mode));
    c_window_end: cover property ($fell(window_open[0]));
endmodule // scu_props
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench joining both ends of the switch control link
`timescale 1ns/1ps
`default_nettype none
`include "scu_defs.svh"
module tb;
    localparam logic [127:0] DLY_SET = {8{16'h0014}};
    localparam int LIMIT = 4000;
    localparam logic [63:0] PAR_INIT = 64'h1122_3344_5566_7788;
    localparam logic [63:0] PAR_NEXT = 64'h8877_6655_4433_2211;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reset_pin_n = 1'b1;
    logic address_select_pin = 1'b1;
    logic [63:0] par_cfg = PAR_INIT;
    logic cmd_valid = 1'b0;
    logic cmd_read = 1'b0;
    logic cmd_addr_sel = 1'b1;
    logic [7:0] cmd_index = 8'h00;
    logic [7:0] cmd_wdata = 8'h00;
    logic cmd_ready, rsp_valid, rsp_nack, serial_mode;
    logic [7:0] rsp_data, window_open;
    logic [63:0] phys_cfg;
    int miscompares = 0;
    int compares = 0;
    scu_if u_scu_if ();
    scu_slave #(.NUM_REGS(8), .DLY_CYCLES(DLY_SET)) u_scu_slave (
        .clk(clk), .rst(rst), .bus(u_scu_if.slave),
        .reset_pin_n(reset_pin_n), .address_select_pin(address_select_pin),
        .par_cfg(par_cfg), .phys_cfg(phys_cfg), .window_open(window_open),
        .serial_mode(serial_mode));
    scu_master #(.QUARTER_CYCLES(4)) u_scu_master (
        .clk(clk), .rst(rst), .bus(u_scu_if.master),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
        .cmd_addr_sel(cmd_addr_sel), .cmd_index(cmd_index),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_nack(rsp_nack));
    scu_props #(.DLY(20)) u_scu_props (
        .clk(clk), .rst(rst), .m_sda_oe(u_scu_if.m_sda_oe),
        .s_sda_oe(u_scu_if.s_sda_oe), .scl(u_scu_if.scl), .sda(u_scu_if.sda),
        .reset_pin_n(reset_pin_n), .address_select_pin(address_select_pin),
        .serial_mode(serial_mode), .window_open(window_open));
    always #4 clk = ~clk;
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Sample a little after the edge so its updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic xfer(input logic rd, input logic sel, input logic [7:0] idx,
                        input logic [7:0] wd);
        int n;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_read <= rd;
        cmd_addr_sel <= sel;
        cmd_index <= idx;
        cmd_wdata <= wd;
        // Handshakes judged mid-cycle, clear of the edge that moves them
        for (n = 0; n < LIMIT; n++) begin
            @(negedge clk);
            if (cmd_ready === 1'b1) break;
        end
        @(posedge clk);
        cmd_valid <= 1'b0;
        for (n = 0; n < LIMIT; n++) begin
            @(negedge clk);
            if (rsp_valid === 1'b1) break;
        end
        #1;
        if (n == LIMIT) begin
            miscompares++;
            $display("Error at %0t ns: seen %0h expected %0h", $time, 0, 1);
            complete_run();
        end
    endtask
    // Second pin change lands inside the first window: no restart expected
    task automatic test_parallel();
        check(phys_cfg, PAR_INIT);
        check(serial_mode, 1'b0);
        @(posedge clk);
        par_cfg[7:0] <= 8'h3c;
        tick(5);
        check(phys_cfg[7:0], 8'h3c);
        check(window_open, 8'h01);
        @(posedge clk);
        par_cfg[7:0] <= 8'hc3;
        tick(4);
        check(phys_cfg[7:0], 8'h3c);
        tick(17);
        check(window_open, 8'h00);
        check(phys_cfg[7:0], 8'hc3);
        xfer(1'b0, 1'b0, 8'h00, 8'h55);
        check(rsp_nack, 1'b1);
        check(serial_mode, 1'b0);
        check(phys_cfg[7:0], 8'hc3);
        $display("test_parallel done");
    endtask
    task automatic test_serial();
        xfer(1'b0, 1'b1, 8'h02, 8'ha5);
        check(rsp_nack, 1'b0);
        check(window_open, 8'h00);
        check(serial_mode, 1'b1);
        check(phys_cfg[23:16], 8'ha5);
        @(posedge clk);
        par_cfg[23:16] <= 8'h00;
        tick(10);
        check(phys_cfg[23:16], 8'ha5);
        check(window_open, 8'h00);
        $display("test_serial done");
    endtask
    // Lone high or low bit catches a reversed bit order
    task automatic test_readback();
        logic [7:0] idx [4] = '{8'h00, 8'h05, 8'h07, 8'h08};
        logic [7:0] dat [4] = '{8'h80, 8'h01, 8'h96, 8'h5a};
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, 1'b1, idx[i], dat[i]);
            check(rsp_nack, 1'b0);
            xfer(1'b1, 1'b1, idx[i], 8'h00);
            check(rsp_nack, 1'b0);
            check(rsp_data, (i == 3) ? `SCU_RD_FILL : dat[i]);
        end
        $display("test_readback done");
    endtask
    task automatic test_reset_pin();
        @(posedge clk);
        reset_pin_n <= 1'b0;
        par_cfg <= PAR_NEXT;
        address_select_pin <= 1'b0;
        repeat (10) @(posedge clk);
        reset_pin_n <= 1'b1;
        tick(4);
        check(phys_cfg, PAR_NEXT);
        check(serial_mode, 1'b0);
        @(posedge clk);
        par_cfg[15:8] <= 8'h99;
        tick(5);
        check(phys_cfg[15:8], 8'h99);
        xfer(1'b0, 1'b0, 8'h01, 8'h42);
        check(rsp_nack, 1'b0);
        check(phys_cfg[15:8], 8'h42);
        $display("test_reset_pin done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        tick(4);
        test_parallel();
        test_serial();
        test_readback();
        test_reset_pin();
        complete_run();
    end
endmodule // tb
`default_nettype wire
